// ===== hdl/mrw_pkg.sv
// Package for the mode-1 rail and watchdog configuration bank.
// Assumes one 40 MHz clock domain and a two-wire target port sampled on that clock.
package mrw_pkg;

	////////////////////////////////////////////////////////////////////////////
	// Register map
	localparam logic [7:0] MRW_RAIL_OFS = 8'h28;
	localparam logic [7:0] MRW_TMO_OFS = 8'h29;
	localparam logic [7:0] MRW_RAIL_RST = 8'h4F;
	localparam logic [7:0] MRW_TMO_RST = 8'h0C;
	localparam logic [7:0] MRW_UNMAPPED_RD = 8'h00;

	// Arbitrary target address, not tied to any real part
	localparam logic [6:0] MRW_DEV_ADDR = 7'h2A;

	////////////////////////////////////////////////////////////////////////////
	// Level decode, millivolts
	localparam logic [11:0] MRW_STEP_MV = 12'h019;
	localparam logic [11:0] MRW_AON_BASE_MV = 12'h6A4;
	localparam logic [4:0] MRW_AON_MAX_CODE = 5'h08;
	localparam logic [11:0] MRW_SYS_BASE_MV = 12'h5DC;
	localparam logic [4:0] MRW_SYS_MAX_CODE = 5'h18;
	localparam logic [11:0] MRW_BOOST_MV = 12'h4B0;
	localparam logic [11:0] MRW_RST_LEVEL_MV = 12'h708;

	////////////////////////////////////////////////////////////////////////////
	// Watchdog timeout codes and periods in seconds
	localparam logic [1:0] MRW_WD_OFF = 2'h0;
	localparam logic [1:0] MRW_WD_16 = 2'h1;
	localparam logic [1:0] MRW_WD_32 = 2'h2;
	localparam logic [7:0] MRW_WD_16_S = 8'h10;
	localparam logic [7:0] MRW_WD_32_S = 8'h20;
	localparam logic [7:0] MRW_WD_64_S = 8'h40;

	////////////////////////////////////////////////////////////////////////////
	// Field layouts, msb first
	typedef struct packed {
		logic [3:0] aon_reg_level_m1;
		logic core_buck_on_m1;
		logic sys_buck_on_m1;
		logic aon_reg_on_m1;
		logic sys_linreg_on_m1;
	} mrw_rail_cfg_t;

	typedef struct packed {
		logic [1:0] timeout_select_m1;
		logic sys_linreg_boost_m1;
		logic [4:0] sys_linreg_base_m1;
	} mrw_tmo_cfg_t;

	// Settings handed to the regulators and watchdog
	typedef struct packed {
		logic core_buck_on;
		logic sys_buck_on;
		logic aon_reg_on;
		logic sys_linreg_on;
		logic [11:0] aon_mv;
		logic [11:0] sys_mv;
		logic [7:0] wd_sec;
	} mrw_apply_t;

	localparam mrw_apply_t MRW_APPLY_RST = '{1'b1, 1'b1, 1'b1, 1'b1,
		MRW_RST_LEVEL_MV, MRW_RST_LEVEL_MV, 8'h00};

	typedef enum logic [2:0] {
		MRW_IDLE = 3'b000,
		MRW_ADDR = 3'b001,
		MRW_ACK_A = 3'b010,
		MRW_WR = 3'b011,
		MRW_ACK_W = 3'b100,
		MRW_RD = 3'b101,
		MRW_RD_ACK = 3'b110
	} mrw_state_t;

endpackage : mrw_pkg

// ===== hdl/mrw_level_dec.sv
// Saturating level decode for the two linear regulator codes.
// Assumes stable register fields on its inputs; purely combinational.
`timescale 1ns/1ps
module mrw_level_dec (
	input wire logic [3:0] aon_code,
	input wire logic [4:0] sys_code,
	input wire logic sys_boost,
	output logic [11:0] aon_mv,
	output logic [11:0] sys_mv
);
	import mrw_pkg::*;

	// Codes past the top of the table saturate at the last entry
	function automatic logic [11:0] sat_level(input logic [4:0] code, input logic [4:0] max_code,
		input logic [11:0] base);
		logic [4:0] c;
		c = (code > max_code) ? max_code : code;
		sat_level = base + 12'(c) * MRW_STEP_MV;
	endfunction : sat_level

	////////////////////////////////////////////////////////////////////////////
	// Always-on and system regulator levels
	always_comb begin
		aon_mv = sat_level({1'b0, aon_code}, MRW_AON_MAX_CODE, MRW_AON_BASE_MV);
		sys_mv = sat_level(sys_code, MRW_SYS_MAX_CODE, MRW_SYS_BASE_MV) +
			(sys_boost ? MRW_BOOST_MV : 12'h000);
	end
endmodule : mrw_level_dec

// ===== hdl/mrw_wd_dec.sv
// Watchdog timeout select to period in seconds; zero means disabled.
// Assumes the counter elsewhere treats a zero period as off.
`timescale 1ns/1ps
module mrw_wd_dec (
	input wire logic [1:0] sel,
	output logic [7:0] wd_sec
);
	import mrw_pkg::*;

	// Four codes, all legal
	always_comb begin
		unique case (sel)
			MRW_WD_OFF: wd_sec = 8'h00;
			MRW_WD_16: wd_sec = MRW_WD_16_S;
			MRW_WD_32: wd_sec = MRW_WD_32_S;
			default: wd_sec = MRW_WD_64_S;
		endcase
	end
endmodule : mrw_wd_dec

// ===== hdl/mrw_cfg_bank.sv
// Mode-1 rail enable, level and watchdog configuration bank behind a two-wire target port.
// Assumes scl and sda inputs already synchronous to ref_clk, and an external open-drain pad.
// Summary of operation
// - Bits 7:4 at 28h set always-on level
// - Bit 3 at 28h enables core buck
// - Bit 2 at 28h enables system buck
// - Bit 1 at 28h enables always-on regulator
// - Bit 0 at 28h enables system regulator
// - Bits 7:6 at 29h pick watchdog timeout
// - Bit 5 at 29h adds 1.2 V offset
// - Bits 4:0 at 29h set system level
// - Both registers read back last written value
`timescale 1ns/1ps
module mrw_cfg_bank (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic scl,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe,
	input wire logic mode1_active,
	output mrw_pkg::mrw_apply_t apply
);
	import mrw_pkg::*;

	mrw_state_t state_q, state_d;
	logic [3:0] cnt_q, cnt_d;
	logic [7:0] shift_q, shift_d;
	logic [7:0] ptr_q, ptr_d;
	logic first_q, first_d;
	logic rw_q, rw_d;
	logic nack_q, nack_d;
	logic oe_q, oe_d;
	logic scl_q, sda_q;
	mrw_rail_cfg_t rail_q, rail_d;
	mrw_tmo_cfg_t tmo_q, tmo_d;
	mrw_apply_t apply_q, apply_d;
	logic [11:0] aon_mv, sys_mv;
	logic [7:0] wd_sec;
	logic scl_rise, scl_fall, start_c, stop_c;
	logic wr_en;
	logic [7:0] wr_data;

	// Unmapped pointers read zero and swallow writes
	function automatic logic [7:0] rd_byte(input logic [7:0] p, input mrw_rail_cfg_t r,
		input mrw_tmo_cfg_t t);
		if (p == MRW_RAIL_OFS) rd_byte = r;
		else if (p == MRW_TMO_OFS) rd_byte = t;
		else rd_byte = MRW_UNMAPPED_RD;
	endfunction : rd_byte

	////////////////////////////////////////////////////////////////////////////
	// Bus line events from the previous sample
	always_comb begin
		scl_rise = scl & ~scl_q;
		scl_fall = ~scl & scl_q;
		start_c = scl & scl_q & sda_q & ~sda_in;
		stop_c = scl & scl_q & ~sda_q & sda_in;
	end

	////////////////////////////////////////////////////////////////////////////
	// Target protocol: address, pointer byte, then auto-incrementing data
	always_comb begin
		state_d = state_q;
		cnt_d = cnt_q;
		shift_d = shift_q;
		ptr_d = ptr_q;
		first_d = first_q;
		rw_d = rw_q;
		nack_d = nack_q;
		oe_d = oe_q;
		wr_en = 1'b0;
		wr_data = shift_q;
		if (start_c) begin
			// Repeated start keeps the pointer for a following read
			state_d = MRW_ADDR;
			cnt_d = 4'h0;
			oe_d = 1'b0;
		end else if (stop_c) begin
			state_d = MRW_IDLE;
			oe_d = 1'b0;
		end else begin
			unique case (state_q)
				MRW_IDLE: begin
					oe_d = 1'b0;
				end
				MRW_ADDR, MRW_WR: begin
					if (scl_rise) begin
						shift_d = {shift_q[6:0], sda_in};
						cnt_d = cnt_q + 4'h1;
					end else if (scl_fall && cnt_q == 4'h8) begin
						cnt_d = 4'h0;
						if (state_q == MRW_ADDR) begin
							// Foreign address: stay silent until next start
							if (shift_q[7:1] == MRW_DEV_ADDR) begin
								state_d = MRW_ACK_A;
								rw_d = shift_q[0];
								oe_d = 1'b1;
							end else begin
								state_d = MRW_IDLE;
							end
						end else begin
							state_d = MRW_ACK_W;
							oe_d = 1'b1;
							if (first_q) begin
								ptr_d = shift_q;
								first_d = 1'b0;
							end else begin
								wr_en = 1'b1;
								ptr_d = ptr_q + 8'h01;
							end
						end
					end
				end
				MRW_ACK_A: begin
					if (scl_fall) begin
						cnt_d = 4'h0;
						if (rw_q) begin
							shift_d = rd_byte(ptr_q, rail_q, tmo_q);
							ptr_d = ptr_q + 8'h01;
							oe_d = ~shift_d[7];
							state_d = MRW_RD;
						end else begin
							oe_d = 1'b0;
							first_d = 1'b1;
							state_d = MRW_WR;
						end
					end
				end
				MRW_ACK_W: begin
					if (scl_fall) begin
						oe_d = 1'b0;
						state_d = MRW_WR;
					end
				end
				MRW_RD: begin
					if (scl_rise) begin
						cnt_d = cnt_q + 4'h1;
					end else if (scl_fall) begin
						if (cnt_q == 4'h8) begin
							oe_d = 1'b0;
							state_d = MRW_RD_ACK;
						end else begin
							shift_d = {shift_q[6:0], 1'b0};
							oe_d = ~shift_d[7];
						end
					end
				end
				MRW_RD_ACK: begin
					if (scl_rise) begin
						nack_d = sda_in;
					end else if (scl_fall) begin
						if (nack_q) begin
							state_d = MRW_IDLE;
						end else begin
							cnt_d = 4'h0;
							shift_d = rd_byte(ptr_q, rail_q, tmo_q);
							ptr_d = ptr_q + 8'h01;
							oe_d = ~shift_d[7];
							state_d = MRW_RD;
						end
					end
				end
				default: begin
					state_d = MRW_IDLE;
					oe_d = 1'b0;
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Configuration storage; reads have no side effect on any field
	always_comb begin
		rail_d = rail_q;
		tmo_d = tmo_q;
		if (wr_en && ptr_q == MRW_RAIL_OFS) rail_d = wr_data;
		if (wr_en && ptr_q == MRW_TMO_OFS) tmo_d = wr_data;
	end

	mrw_level_dec u_level (
		.aon_code(rail_q.aon_reg_level_m1),
		.sys_code(tmo_q.sys_linreg_base_m1),
		.sys_boost(tmo_q.sys_linreg_boost_m1),
		.aon_mv(aon_mv),
		.sys_mv(sys_mv)
	);

	mrw_wd_dec u_wd (
		.sel(tmo_q.timeout_select_m1),
		.wd_sec(wd_sec)
	);

	////////////////////////////////////////////////////////////////////////////
	// Applied settings follow storage only in mode 1, otherwise hold
	always_comb begin
		apply_d = apply_q;
		if (mode1_active) begin
			apply_d.core_buck_on = rail_q.core_buck_on_m1;
			apply_d.sys_buck_on = rail_q.sys_buck_on_m1;
			apply_d.aon_reg_on = rail_q.aon_reg_on_m1;
			apply_d.sys_linreg_on = rail_q.sys_linreg_on_m1;
			apply_d.aon_mv = aon_mv;
			apply_d.sys_mv = sys_mv;
			apply_d.wd_sec = wd_sec;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Registers
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			state_q <= MRW_IDLE;
			cnt_q <= 4'h0;
			shift_q <= 8'h00;
			ptr_q <= 8'h00;
			first_q <= 1'b0;
			rw_q <= 1'b0;
			nack_q <= 1'b0;
			oe_q <= 1'b0;
			scl_q <= 1'b1;
			sda_q <= 1'b1;
			rail_q <= MRW_RAIL_RST;
			tmo_q <= MRW_TMO_RST;
			apply_q <= MRW_APPLY_RST;
		end else begin
			state_q <= state_d;
			cnt_q <= cnt_d;
			shift_q <= shift_d;
			ptr_q <= ptr_d;
			first_q <= first_d;
			rw_q <= rw_d;
			nack_q <= nack_d;
			oe_q <= oe_d;
			scl_q <= scl;
			sda_q <= sda_in;
			rail_q <= rail_d;
			tmo_q <= tmo_d;
			apply_q <= apply_d;
		end
	end

	// Open drain: only ever pulls low
	always_comb begin
		sda_out = 1'b0;
		sda_oe = oe_q;
		apply = apply_q;
	end

	////////////////////////////////////////////////////////////////////////////
	// Checks
	property p_aon_level;
		@(posedge ref_clk) disable iff (rst)
		mode1_active && rail_q.aon_reg_level_m1 <= 4'h8 |=>
			apply_q.aon_mv == 12'h6A4 + 12'h019 * 12'($past(rail_q.aon_reg_level_m1));
	endproperty
	a_aon_level: assert property (p_aon_level) else $error("always-on level wrong");

	property p_aon_sat;
		@(posedge ref_clk) disable iff (rst)
		mode1_active && rail_q.aon_reg_level_m1 > 4'h8 |=> apply_q.aon_mv == 12'h76C;
	endproperty
	a_aon_sat: assert property (p_aon_sat) else $error("always-on level not saturated");

	property p_core_en;
		@(posedge ref_clk) disable iff (rst)
		mode1_active |=> apply_q.core_buck_on == $past(rail_q.core_buck_on_m1);
	endproperty
	a_core_en: assert property (p_core_en) else $error("core buck enable wrong");

	property p_sys_buck_en;
		@(posedge ref_clk) disable iff (rst)
		mode1_active |=> apply_q.sys_buck_on == $past(rail_q.sys_buck_on_m1);
	endproperty
	a_sys_buck_en: assert property (p_sys_buck_en) else $error("system buck enable wrong");

	property p_aon_en;
		@(posedge ref_clk) disable iff (rst)
		mode1_active |=> apply_q.aon_reg_on == $past(rail_q.aon_reg_on_m1);
	endproperty
	a_aon_en: assert property (p_aon_en) else $error("always-on enable wrong");

	property p_sys_lin_en;
		@(posedge ref_clk) disable iff (rst)
		mode1_active |=> apply_q.sys_linreg_on == $past(rail_q.sys_linreg_on_m1);
	endproperty
	a_sys_lin_en: assert property (p_sys_lin_en) else $error("system regulator enable wrong");

	property p_wd_32;
		@(posedge ref_clk) disable iff (rst)
		mode1_active && tmo_q.timeout_select_m1 == 2'h2 |=> apply_q.wd_sec == 8'h20;
	endproperty
	a_wd_32: assert property (p_wd_32) else $error("watchdog period wrong");

	property p_boost;
		@(posedge ref_clk) disable iff (rst)
		mode1_active && tmo_q.sys_linreg_boost_m1 |=> apply_q.sys_mv >= 12'hA8C;
	endproperty
	a_boost: assert property (p_boost) else $error("offset not added");

	property p_sys_sat;
		@(posedge ref_clk) disable iff (rst)
		mode1_active && !tmo_q.sys_linreg_boost_m1 && tmo_q.sys_linreg_base_m1 > 5'h18 |=>
			apply_q.sys_mv == 12'h834;
	endproperty
	a_sys_sat: assert property (p_sys_sat) else $error("system level not saturated");

	property p_store;
		@(posedge ref_clk) disable iff (rst)
		wr_en && ptr_q == 8'h29 |=> tmo_q == $past(wr_data) ##1 $stable(tmo_q) || wr_en;
	endproperty
	a_store: assert property (p_store) else $error("write not stored");

	property p_hold;
		@(posedge ref_clk) disable iff (rst)
		!mode1_active |=> $stable(apply_q);
	endproperty
	a_hold: assert property (p_hold) else $error("settings changed outside mode 1");
endmodule : mrw_cfg_bank

// ===== test/mrw_host.sv
// Two-wire host model that stands in for the microcontroller.
// Assumes the bench resolves the open-drain data line with a pull-up.
`timescale 1ns/1ps
module mrw_host (
	input wire logic ref_clk,
	input wire logic sda,
	output logic scl,
	output logic sda_low
);
	import mrw_pkg::*;

	////////////////////////////////////////////////////////////////////////////
	// Bus idles with both lines released
	initial begin
		scl = 1'b1;
		sda_low = 1'b0;
	end

	task automatic tk(input int n);
		repeat (n) @(posedge ref_clk);
	endtask : tk

	// Data moves only while the clock is low, never on its edge
	task automatic put_bit(input logic b);
		sda_low <= ~b;
		tk(2);
		scl <= 1'b1;
		tk(4);
		scl <= 1'b0;
		tk(2);
	endtask : put_bit

	// Sampled mid-high, long after the target last moved the line
	task automatic get_bit(output logic b);
		sda_low <= 1'b0;
		tk(2);
		scl <= 1'b1;
		tk(2);
		b = sda;
		tk(2);
		scl <= 1'b0;
		tk(2);
	endtask : get_bit

	// Start or repeated start: data falls while clock high
	task automatic start;
		sda_low <= 1'b0;
		tk(2);
		scl <= 1'b1;
		tk(4);
		sda_low <= 1'b1;
		tk(4);
		scl <= 1'b0;
		tk(2);
	endtask : start

	task automatic stop;
		sda_low <= 1'b1;
		tk(2);
		scl <= 1'b1;
		tk(4);
		sda_low <= 1'b0;
		tk(4);
	endtask : stop

	// Byte out, msb first, then the target acknowledge
	task automatic send(input logic [7:0] v, output logic ack);
		logic b;
		for (int i = 7; i >= 0; i--) put_bit(v[i]);
		get_bit(b);
		ack = ~b;
	endtask : send

	task automatic recv(output logic [7:0] v, input logic last);
		logic b;
		for (int i = 7; i >= 0; i--) begin
			get_bit(b);
			v[i] = b;
		end
		put_bit(last);
	endtask : recv

	// Pointer then one or two data bytes; ok is every acknowledge
	task automatic write(input logic [6:0] dev, input logic [7:0] ptr, input logic [7:0] d0,
		input logic [7:0] d1, input logic two, output logic ok);
		logic a;
		start;
		send({dev, 1'b0}, ok);
		if (ok) begin
			send(ptr, a);
			ok &= a;
			send(d0, a);
			ok &= a;
			if (two) begin
				send(d1, a);
				ok &= a;
			end
		end
		stop;
	endtask : write

	// Pointer, repeated start, two bytes; the last is refused
	task automatic read(input logic [7:0] ptr, output logic [7:0] r0, output logic [7:0] r1);
		logic a;
		start;
		send({MRW_DEV_ADDR, 1'b0}, a);
		send(ptr, a);
		start;
		send({MRW_DEV_ADDR, 1'b1}, a);
		recv(r0, 1'b0);
		recv(r1, 1'b1);
		stop;
	endtask : read

endmodule : mrw_host

// ===== test/testbench.sv
// Self-checking bench for the mode-1 configuration bank.
// Assumes mrw_host as bus host and a pull-up on the data line.
`timescale 1ns/1ps
module testbench;
	import mrw_pkg::*;

	////////////////////////////////////////////////////////////////////////////
	logic ref_clk;
	logic rst;
	logic mode1_active;
	logic scl;
	logic host_low;
	logic sda_out;
	logic sda_oe;
	mrw_apply_t apply;
	logic [7:0] rail_s = 8'h4F;
	logic [7:0] tmo_s = 8'h0C;
	int failures = 0;
	int cmp_count = 0;
	int cycles = 0;

	// Open-drain data line, pulled up when nobody pulls
	wire sda_line = !((sda_oe && !sda_out) || host_low);

	mrw_cfg_bank dut_u (.ref_clk(ref_clk), .rst(rst), .scl(scl), .sda_in(sda_line), .sda_out(sda_out),
		.sda_oe(sda_oe), .mode1_active(mode1_active), .apply(apply));
	mrw_host host_u (.ref_clk(ref_clk), .sda(sda_line), .scl(scl), .sda_low(host_low));

	always #12.5 ref_clk = ~ref_clk;

	// Hang guard, well above the roughly 18k cycles needed
	always @(posedge ref_clk) begin
		cycles <= cycles + 1;
		if (cycles == 40000) begin
			failures++;
			conclude();
		end
	end

	////////////////////////////////////////////////////////////////////////////
	task automatic conclude;
		if (failures == 0 && cmp_count > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask : conclude

	task automatic cmp_apply(input string what, input mrw_apply_t e, input mrw_apply_t g);
		cmp_count++;
		if (g !== e) begin
			failures++;
			$display("BAD %s expected %h seen %h", what, e, g);
		end
	endtask : cmp_apply

	task automatic cmp_byte(input string what, input logic [7:0] e, input logic [7:0] g);
		cmp_count++;
		if (g !== e) begin
			failures++;
			$display("BAD %s expected %h seen %h", what, e, g);
		end
	endtask : cmp_byte

	// Expected settings worked out from the register fields
	function automatic mrw_apply_t exp_apply(input logic [7:0] r, input logic [7:0] t);
		mrw_apply_t e;
		e.core_buck_on = r[3];
		e.sys_buck_on = r[2];
		e.aon_reg_on = r[1];
		e.sys_linreg_on = r[0];
		e.aon_mv = (r[7:4] > 4'h8) ? 12'h76C : 12'h6A4 + 12'h019 * r[7:4];
		e.sys_mv = ((t[4:0] > 5'h18) ? 12'h834 : 12'h5DC + 12'h019 * t[4:0])
			+ (t[5] ? 12'h4B0 : 12'h000);
		e.wd_sec = (t[7:6] == 2'h0) ? 8'h00 : 8'h08 << t[7:6];
		return e;
	endfunction : exp_apply

	// Both registers in one auto-incrementing write
	task automatic set_regs(input logic [7:0] r, input logic [7:0] t);
		logic ok;
		host_u.write(MRW_DEV_ADDR, 8'h28, r, t, 1'b1, ok);
		cmp_byte("write ack", 8'h01, {7'h00, ok});
		rail_s = r;
		tmo_s = t;
		host_u.tk(3);
	endtask : set_regs

	////////////////////////////////////////////////////////////////////////////
	task automatic t_reset;
		logic [7:0] r0;
		logic [7:0] r1;
		cmp_apply("reset apply", exp_apply(8'h4F, 8'h0C), apply);
		host_u.read(8'h28, r0, r1);
		cmp_byte("reset 28h", 8'h4F, r0);
		cmp_byte("reset 29h", 8'h0C, r1);
	endtask : t_reset

	// Every level code, every enable combination
	task automatic t_rail;
		for (int c = 0; c < 16; c++) begin
			set_regs({c[3:0], c[3:0]}, tmo_s);
			cmp_apply("rail", exp_apply(rail_s, tmo_s), apply);
		end
	endtask : t_rail

	// Every base code, both offsets, every timeout
	task automatic t_tmo;
		for (int c = 0; c < 32; c++) begin
			set_regs(rail_s, {c[1:0], c[2], c[4:0]});
			cmp_apply("timeout and level", exp_apply(rail_s, tmo_s), apply);
		end
	endtask : t_tmo

	task automatic t_readback;
		logic [7:0] r0;
		logic [7:0] r1;
		logic ok;
		set_regs(8'hA5, 8'h5A);
		host_u.read(8'h28, r0, r1);
		cmp_byte("read 28h", 8'hA5, r0);
		cmp_byte("read 29h", 8'h5A, r1);
		host_u.read(8'h29, r0, r1);
		cmp_byte("reread 29h", 8'h5A, r0);
		cmp_byte("read unmapped", 8'h00, r1);
		host_u.write(7'h15, 8'h28, 8'h00, 8'h00, 1'b0, ok);
		cmp_byte("foreign ack", 8'h00, {7'h00, ok});
		cmp_apply("after foreign", exp_apply(8'hA5, 8'h5A), apply);
	endtask : t_readback

	// Writes outside mode 1 are stored, applied on return
	task automatic t_mode;
		logic [7:0] r0;
		logic [7:0] r1;
		mrw_apply_t old;
		old = exp_apply(rail_s, tmo_s);
		mode1_active <= 1'b0;
		set_regs(8'h30, 8'hFF);
		cmp_apply("held outside mode 1", old, apply);
		host_u.read(8'h28, r0, r1);
		cmp_byte("stored 28h", 8'h30, r0);
		cmp_byte("stored 29h", 8'hFF, r1);
		mode1_active <= 1'b1;
		host_u.tk(3);
		cmp_apply("applied in mode 1", exp_apply(8'h30, 8'hFF), apply);
	endtask : t_mode

	////////////////////////////////////////////////////////////////////////////
	// Main sequence, with a second reset mid-run
	initial begin
		// Driven from here so that the clock, reset and mode pins are exercised, not tied
		ref_clk = 1'b0;
		rst = 1'b1;
		mode1_active = 1'b1;
		host_u.tk(10);
		rst <= 1'b0;
		host_u.tk(2);
		t_reset();
		t_rail();
		t_tmo();
		t_readback();
		t_mode();
		rst <= 1'b1;
		host_u.tk(2);
		rst <= 1'b0;
		host_u.tk(2);
		t_reset();
		conclude();
	end

endmodule : testbench
